//--- src/ccr_pkg.sv
// Purpose: constants and carriers for the clock control register block
// Assumes: 8-bit register port, single 200 MHz clock
// Notes:   register offsets are word indices on the plain register port
package ccr_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [2:0] OFS_PLL_CONTROL    = 3'h0;
    localparam logic [2:0] OFS_BW_CONTROL     = 3'h1;
    localparam logic [2:0] OFS_FB_MULT_HIGH   = 3'h2;
    localparam logic [2:0] OFS_FB_MULT_LOW    = 3'h3;
    localparam logic [2:0] OFS_VCO_LIN_RANGE  = 3'h4;
    localparam logic [2:0] OFS_REF_DIVIDER    = 3'h5;

    // pll_control fields
    localparam int BIT_LOCK_IE   = 7;
    localparam int BIT_LOCK_FLAG = 6;
    localparam int BIT_PLL_ON    = 5;
    localparam int BIT_BASE_SEL  = 4;
    localparam int POS_PRESCALER = 2;
    localparam int POS_VCO_POW2  = 0;
    // pll_bandwidth_control fields
    localparam int BIT_AUTO_BW   = 7;
    localparam int BIT_LOCK      = 6;
    localparam int BIT_PHASE     = 5;

    // ----------------------------------------------------------------
    // reset values and clock switch edge count
    // ----------------------------------------------------------------
    localparam logic [11:0] RST_FB_MULT   = 12'h040;
    localparam logic [7:0]  RST_LIN_RANGE = 8'h40;
    localparam logic [3:0]  RST_REF_DIV   = 4'h1;
    localparam logic [1:0]  SWITCH_EDGES  = 2'h3;

    typedef enum logic [0:0] {
        CK_RUN    = 1'b0,
        CK_SWITCH = 1'b1
    } ccr_ck_state_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccr_bus_req_t;

    // settings handed to the analog loop
    typedef struct packed {
        logic        pll_enable;
        logic [1:0]  prescaler;
        logic [1:0]  vco_pow2_range;
        logic        auto_bandwidth;
        logic        manual_phase;
        logic [11:0] feedback_multiplier;
        logic [7:0]  linear_range_multiplier;
        logic [3:0]  reference_divide_select;
    } ccr_pll_cfg_t;

endpackage : ccr_pkg

//--- src/ccr_clock_regs.sv
// Purpose: register set and base clock selector of the PLL clock generator
// Assumes: oscillator and divided VCO clocks arrive as sampled levels below 100 MHz
// Notes:   base clock out is a sampled-domain divide-by-two, not a clock tree cell
`timescale 1ns/1ps

module ccr_clock_regs
    import ccr_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire ccr_pkg::ccr_bus_req_t bus_req,
    output logic [7:0]               rd_data,
    input  wire logic                oscillator_clock,
    input  wire logic                divided_vco_clock,
    input  wire logic                pll_locked,
    input  wire logic                pll_tracking,
    output logic                     base_clock_out,
    output logic                     lock_irq,
    output ccr_pkg::ccr_pll_cfg_t    pll_cfg
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic          lock_ie;
        logic          lock_flag;
        logic          pll_on;
        logic          base_sel;
        logic [1:0]    prescaler;
        logic [1:0]    vco_pow2;
        logic          auto_bw;
        logic          lock;
        logic          manual_phase;
        logic [11:0]   fb_mult;
        logic [7:0]    lin_range;
        logic [3:0]    ref_div;
        logic [7:0]    rdata;
        logic [2:0]    osc_sync;
        logic [2:0]    vco_sync;
        logic [1:0]    lock_sync;
        logic [1:0]    trk_sync;
        ccr_ck_state_t ck_state;
        logic          active_sel;
        logic [1:0]    osc_cnt;
        logic [1:0]    vco_cnt;
        logic          base_clk;
        logic          irq;
        ccr_pll_cfg_t  cfg;
    } ccr_state_t;

    localparam ccr_state_t STATE_RESET = '{
        lock_ie:      1'b0,
        lock_flag:    1'b0,
        pll_on:       1'b1,
        base_sel:     1'b0,
        prescaler:    2'h0,
        vco_pow2:     2'h0,
        auto_bw:      1'b0,
        lock:         1'b0,
        manual_phase: 1'b0,
        fb_mult:      RST_FB_MULT,
        lin_range:    RST_LIN_RANGE,
        ref_div:      RST_REF_DIV,
        rdata:        8'h00,
        osc_sync:     3'h0,
        vco_sync:     3'h0,
        lock_sync:    2'h0,
        trk_sync:     2'h0,
        ck_state:     CK_RUN,
        active_sel:   1'b0,
        osc_cnt:      2'h0,
        vco_cnt:      2'h0,
        base_clk:     1'b0,
        irq:          1'b0,
        cfg:          '{pll_enable: 1'b1,
                        prescaler: 2'h0,
                        vco_pow2_range: 2'h0,
                        auto_bandwidth: 1'b0,
                        manual_phase: 1'b0,
                        feedback_multiplier: RST_FB_MULT,
                        linear_range_multiplier: RST_LIN_RANGE,
                        reference_divide_select: RST_REF_DIV}
    };

    ccr_state_t state_reg;
    ccr_state_t state_next;

    logic       wr_ctl;
    logic       wr_bw;
    logic       rd_ctl;
    logic [7:0] wd;
    logic       osc_rise;
    logic       vco_rise;
    logic       src_rise;
    logic       lock_now;
    logic       range_zero;
    logic [7:0] ctl_view;
    logic [7:0] bw_view;

    always_comb begin
        state_next = state_reg;
        wd         = bus_req.wdata;
        wr_ctl     = bus_req.wr && (bus_req.addr == OFS_PLL_CONTROL);
        wr_bw      = bus_req.wr && (bus_req.addr == OFS_BW_CONTROL);
        rd_ctl     = bus_req.rd && (bus_req.addr == OFS_PLL_CONTROL);

        // ------------------------------------------------------------
        // input synchronisers; only stage two onward is looked at
        // ------------------------------------------------------------
        state_next.osc_sync  = {state_reg.osc_sync[1:0], oscillator_clock};
        state_next.vco_sync  = {state_reg.vco_sync[1:0], divided_vco_clock};
        state_next.lock_sync = {state_reg.lock_sync[0], pll_locked};
        state_next.trk_sync  = {state_reg.trk_sync[0], pll_tracking};
        osc_rise = state_reg.osc_sync[1] && !state_reg.osc_sync[2];
        vco_rise = state_reg.vco_sync[1] && !state_reg.vco_sync[2];

        // ------------------------------------------------------------
        // lock indicator and change flag
        // ------------------------------------------------------------
        lock_now = state_reg.auto_bw && state_reg.lock_sync[1];
        state_next.lock = lock_now;
        if (!state_reg.auto_bw) begin
            state_next.lock_flag = 1'b0;
        end else if (lock_now != state_reg.lock) begin
            state_next.lock_flag = 1'b1; // set beats a same-cycle read clear
        end else if (rd_ctl) begin
            state_next.lock_flag = 1'b0;
        end

        // ------------------------------------------------------------
        // read views
        // ------------------------------------------------------------
        ctl_view = {state_reg.lock_ie && state_reg.auto_bw,
                    state_reg.lock_flag && state_reg.auto_bw,
                    state_reg.pll_on,
                    state_reg.base_sel,
                    state_reg.prescaler,
                    state_reg.vco_pow2};
        bw_view  = {state_reg.auto_bw,
                    state_reg.lock,
                    state_reg.auto_bw ? state_reg.trk_sync[1] : state_reg.manual_phase,
                    5'h00};

        // ------------------------------------------------------------
        // register reads, data one cycle later, unmapped reads 0
        // ------------------------------------------------------------
        state_next.rdata = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_PLL_CONTROL:   state_next.rdata = ctl_view;
                OFS_BW_CONTROL:    state_next.rdata = bw_view;
                OFS_FB_MULT_HIGH:  state_next.rdata = {4'h0, state_reg.fb_mult[11:8]};
                OFS_FB_MULT_LOW:   state_next.rdata = state_reg.fb_mult[7:0];
                OFS_VCO_LIN_RANGE: state_next.rdata = state_reg.lin_range;
                OFS_REF_DIVIDER:   state_next.rdata = {4'h0, state_reg.ref_div};
                default:           state_next.rdata = 8'h00;
            endcase
        end

        // ------------------------------------------------------------
        // register writes; every guard looks at current values only,
        // so power and select can both change in one write
        // ------------------------------------------------------------
        if (wr_ctl) begin
            if (state_reg.auto_bw) begin
                state_next.lock_ie = wd[BIT_LOCK_IE];
            end
            if (wd[BIT_PLL_ON] || !state_reg.base_sel) begin
                state_next.pll_on = wd[BIT_PLL_ON];
            end
            if (!wd[BIT_BASE_SEL] || (state_reg.pll_on && state_reg.lin_range != 8'h00)) begin
                state_next.base_sel = wd[BIT_BASE_SEL];
            end
            if (!state_reg.pll_on) begin
                state_next.prescaler = wd[POS_PRESCALER +: 2];
                state_next.vco_pow2  = wd[POS_VCO_POW2 +: 2];
            end
        end

        if (wr_bw) begin
            state_next.auto_bw = wd[BIT_AUTO_BW];
            // manual value survives auto mode untouched
            if (!state_reg.auto_bw) begin
                state_next.manual_phase = wd[BIT_PHASE];
            end
        end

        if (bus_req.wr && !state_reg.pll_on) begin
            unique case (bus_req.addr)
                OFS_FB_MULT_HIGH:  state_next.fb_mult[11:8] = wd[3:0];
                OFS_FB_MULT_LOW:   state_next.fb_mult[7:0]  = wd;
                OFS_VCO_LIN_RANGE: state_next.lin_range     = wd;
                OFS_REF_DIVIDER:   state_next.ref_div       = wd[3:0];
                default:           state_next.ref_div       = state_reg.ref_div;
            endcase
        end

        // zero range forces the oscillator back in
        if (state_reg.lin_range == 8'h00) begin
            state_next.base_sel = 1'b0;
        end

        // ------------------------------------------------------------
        // base clock selector
        // ------------------------------------------------------------
        // sources are sampled at 200 MHz, so each must stay below half
        // that rate; the output edge lags the source by three cycles
        src_rise = state_reg.active_sel ? vco_rise : osc_rise;
        unique case (state_reg.ck_state)
            CK_RUN: begin
                if (src_rise) begin
                    state_next.base_clk = !state_reg.base_clk;
                end
                if (state_reg.base_sel != state_reg.active_sel) begin
                    state_next.ck_state = CK_SWITCH;
                    state_next.osc_cnt  = 2'h0;
                    state_next.vco_cnt  = 2'h0;
                end
            end
            CK_SWITCH: begin
                // output held while both sources show three edges
                if (osc_rise && state_reg.osc_cnt != SWITCH_EDGES) begin
                    state_next.osc_cnt = state_reg.osc_cnt + 2'h1;
                end
                if (vco_rise && state_reg.vco_cnt != SWITCH_EDGES) begin
                    state_next.vco_cnt = state_reg.vco_cnt + 2'h1;
                end
                if (state_reg.osc_cnt == SWITCH_EDGES && state_reg.vco_cnt == SWITCH_EDGES) begin
                    state_next.active_sel = state_reg.base_sel;
                    state_next.ck_state   = CK_RUN;
                end
            end
        endcase

        // ------------------------------------------------------------
        // registered outputs
        // ------------------------------------------------------------
        state_next.irq = state_next.lock_flag && state_next.lock_ie
                         && state_next.auto_bw;
        state_next.cfg.pll_enable = state_next.pll_on
                                    && state_next.lin_range != 8'h00;
        state_next.cfg.prescaler      = state_next.prescaler;
        state_next.cfg.vco_pow2_range = state_next.vco_pow2;
        state_next.cfg.auto_bandwidth = state_next.auto_bw;
        state_next.cfg.manual_phase   = state_next.manual_phase;
        state_next.cfg.feedback_multiplier =
            (state_next.fb_mult == 12'h000) ? 12'h001 : state_next.fb_mult;
        state_next.cfg.linear_range_multiplier = state_next.lin_range;
        state_next.cfg.reference_divide_select =
            (state_next.ref_div == 4'h0) ? 4'h1 : state_next.ref_div;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data        = state_reg.rdata;
    assign base_clock_out = state_reg.base_clk;
    assign lock_irq       = state_reg.irq;
    assign pll_cfg        = state_reg.cfg;

endmodule : ccr_clock_regs

//--- verification/ccr_clock_regs_checker.sv
// Purpose: port-level assertions for the clock control register block
// Assumes: single clock, srst synchronous active high
// Notes:   cfg checks tolerate a one-cycle lag of pll_cfg behind the registers
`timescale 1ns/1ps
module ccr_clock_regs_checker (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire ccr_pkg::ccr_bus_req_t bus_req,
    input wire logic [7:0]            rd_data,
    input wire logic                  oscillator_clock,
    input wire logic                  divided_vco_clock,
    input wire logic                  pll_locked,
    input wire logic                  pll_tracking,
    input wire logic                  base_clock_out,
    input wire logic                  lock_irq,
    input wire ccr_pkg::ccr_pll_cfg_t pll_cfg
);
    import ccr_pkg::*;
    // ------------------------------------------------------------
    // quiet-time counter: no write and no lock change for a while
    // ------------------------------------------------------------
    logic [3:0] calm_cnt;
    always_ff @(posedge clk) begin
        if (srst || bus_req.wr || $changed(pll_locked)) begin
            calm_cnt <= 4'h0;
        end else if (calm_cnt != 4'hf) begin
            calm_cnt <= calm_cnt + 4'h1;
        end
    end
    property p_flag_manual;
        @(posedge clk) disable iff (srst)
        bus_req.rd && bus_req.addr == OFS_PLL_CONTROL && !pll_cfg.auto_bandwidth
        && !$past(bus_req.wr) && !$past(bus_req.wr, 2) |=> rd_data[7:6] == 2'b00;
    endproperty
    a_flag_manual: assert property (p_flag_manual) else $error("flag or enable seen in manual");
    property p_lock_manual;
        @(posedge clk) disable iff (srst)
        bus_req.rd && bus_req.addr == OFS_BW_CONTROL && !pll_cfg.auto_bandwidth
        && !$past(bus_req.wr) && !$past(bus_req.wr, 2) |=> rd_data[6] == 1'b0 && rd_data[4:0] == 5'h00;
    endproperty
    a_lock_manual: assert property (p_lock_manual) else $error("lock bit set in manual");
    property p_irq_manual;
        @(posedge clk) disable iff (srst)
        !pll_cfg.auto_bandwidth && !$past(pll_cfg.auto_bandwidth) |-> !lock_irq;
    endproperty
    a_irq_manual: assert property (p_irq_manual) else $error("interrupt in manual mode");
    property p_irq_clear;
        @(posedge clk) disable iff (srst)
        lock_irq && calm_cnt >= 4'h8 && bus_req.rd && bus_req.addr == OFS_PLL_CONTROL
        |-> ##[1:3] !lock_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("control read left flag set");
    property p_cfg_locked;
        @(posedge clk) disable iff (srst)
        pll_cfg.pll_enable && $past(pll_cfg.pll_enable) |-> $stable({pll_cfg.prescaler,
        pll_cfg.vco_pow2_range, pll_cfg.feedback_multiplier,
        pll_cfg.linear_range_multiplier, pll_cfg.reference_divide_select});
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("field changed while on");
    property p_div_nonzero;
        @(posedge clk) disable iff (srst)
        pll_cfg.feedback_multiplier != 12'h000 && pll_cfg.reference_divide_select != 4'h0;
    endproperty
    a_div_nonzero: assert property (p_div_nonzero) else $error("zero divider handed on");
    property p_lin_zero;
        @(posedge clk) disable iff (srst)
        pll_cfg.linear_range_multiplier == 8'h00 |-> !pll_cfg.pll_enable;
    endproperty
    a_lin_zero: assert property (p_lin_zero) else $error("loop enabled with zero range");
    property p_phase_hold;
        @(posedge clk) disable iff (srst)
        pll_cfg.auto_bandwidth && $past(pll_cfg.auto_bandwidth) |-> $stable(pll_cfg.manual_phase);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("manual phase lost in auto");
endmodule : ccr_clock_regs_checker

bind ccr_clock_regs ccr_clock_regs_checker u_checker (
    .clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .oscillator_clock(oscillator_clock), .divided_vco_clock(divided_vco_clock),
    .pll_locked(pll_locked), .pll_tracking(pll_tracking), .base_clock_out(base_clock_out),
    .lock_irq(lock_irq), .pll_cfg(pll_cfg)
);

//--- verification/tb.sv
// Purpose: self-checking bench for the clock control register block
// Assumes: oscillator runs at clk/8, divided VCO at clk/6
// Notes:   rate windows are whole periods so toggle counts are exact
`timescale 1ns/1ps
module tb;
    import ccr_pkg::*;
    logic         clk;
    logic         srst;
    ccr_bus_req_t bus_req;
    logic [7:0]   rd_data;
    logic         oscillator_clock  = 1'b0;
    logic         divided_vco_clock = 1'b0;
    logic         pll_locked;
    logic         pll_tracking;
    logic         base_clock_out;
    logic         lock_irq;
    ccr_pll_cfg_t pll_cfg;
    int           src_cnt = 0;
    int           bad_count;
    int           comparisons;
    ccr_clock_regs u_ccr_clock_regs (
        .clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .oscillator_clock(oscillator_clock), .divided_vco_clock(divided_vco_clock),
        .pll_locked(pll_locked), .pll_tracking(pll_tracking),
        .base_clock_out(base_clock_out), .lock_irq(lock_irq), .pll_cfg(pll_cfg)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        src_cnt           <= src_cnt + 1;
        oscillator_clock  <= (src_cnt % 8) < 4;
        divided_vco_clock <= (src_cnt % 6) < 3;
    end
    // ------------------------------------------------------------
    // shared bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(what, {4'h0, exp}, {4'h0, rd_data});
    endtask : rd
    task automatic rate(input string what, input int period);
        int   flips;
        logic prev;
        flips = 0;
        prev  = base_clock_out;
        repeat (240) begin
            @(posedge clk);
            #1;
            if (base_clock_out !== prev) flips++;
            prev = base_clock_out;
        end
        chk(what, 12'(240 / period), 12'(flips));
    endtask : rate
    task automatic t_reset;
        rd("ctrl", OFS_PLL_CONTROL, 8'h20);
        rd("bw", OFS_BW_CONTROL, 8'h00);
        rd("mul_hi", OFS_FB_MULT_HIGH, 8'h00);
        rd("mul_lo", OFS_FB_MULT_LOW, 8'h40);
        rd("lin", OFS_VCO_LIN_RANGE, 8'h40);
        rd("ref", OFS_REF_DIVIDER, 8'h01);
        rd("unmapped", 3'h6, 8'h00);
    endtask : t_reset
    task automatic t_protect;
        logic [7:0] code;
        wr(OFS_FB_MULT_LOW, 8'h12);
        wr(OFS_VCO_LIN_RANGE, 8'h05);
        wr(OFS_REF_DIVIDER, 8'h03);
        wr(OFS_PLL_CONTROL, 8'h2E);
        rd("ctrl_on", OFS_PLL_CONTROL, 8'h20);
        rd("mul_lo_on", OFS_FB_MULT_LOW, 8'h40);
        rd("lin_on", OFS_VCO_LIN_RANGE, 8'h40);
        rd("ref_on", OFS_REF_DIVIDER, 8'h01);
        wr(OFS_PLL_CONTROL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            // range code 3 is never programmed
            code = {4'h0, 2'(i), 2'(i % 3)};
            wr(OFS_PLL_CONTROL, code);
            rd("codes", OFS_PLL_CONTROL, code);
            chk("pre_cfg", {10'h000, 2'(i)}, {10'h000, pll_cfg.prescaler});
            chk("rng_cfg", {10'h000, 2'(i % 3)}, {10'h000, pll_cfg.vco_pow2_range});
        end
        wr(OFS_PLL_CONTROL, 8'h1E);
        rd("sel_off", OFS_PLL_CONTROL, 8'h0E);
        wr(OFS_FB_MULT_LOW, 8'h00);
        wr(OFS_REF_DIVIDER, 8'h00);
        wr(OFS_VCO_LIN_RANGE, 8'h00);
        wr(OFS_PLL_CONTROL, 8'h2E);
        wr(OFS_PLL_CONTROL, 8'h3E);
        idle(2);
        chk("mul_zero", 12'h001, pll_cfg.feedback_multiplier);
        chk("ref_zero", 12'h001, {8'h00, pll_cfg.reference_divide_select});
        chk("en_lin0", 12'h000, {11'h000, pll_cfg.pll_enable});
        rd("sel_lin0", OFS_PLL_CONTROL, 8'h2E);
        wr(OFS_PLL_CONTROL, 8'h0E);
        wr(OFS_VCO_LIN_RANGE, 8'h40);
        wr(OFS_FB_MULT_LOW, 8'h40);
        wr(OFS_REF_DIVIDER, 8'h01);
        wr(OFS_PLL_CONTROL, 8'h2E);
        idle(2);
        chk("en_on", 12'h001, {11'h000, pll_cfg.pll_enable});
        chk("lin_cfg", 12'h040, {4'h0, pll_cfg.linear_range_multiplier});
    endtask : t_protect
    task automatic t_clock;
        logic prev;
        logic stuck;
        idle(20);
        rate("osc_rate", 8);
        wr(OFS_PLL_CONTROL, 8'h3E);
        idle(2);
        prev  = base_clock_out;
        stuck = 1'b1;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (base_clock_out !== prev) stuck = 1'b0;
        end
        chk("frozen", 12'h001, {11'h000, stuck});
        idle(40);
        rate("vco_rate", 6);
        wr(OFS_PLL_CONTROL, 8'h1E);
        rd("off_refused", OFS_PLL_CONTROL, 8'h3E);
        wr(OFS_PLL_CONTROL, 8'h2E);
        idle(40);
        rate("osc_back", 8);
    endtask : t_clock
    task automatic t_lock;
        wr(OFS_PLL_CONTROL, 8'hAE);
        rd("ie_manual", OFS_PLL_CONTROL, 8'h2E);
        @(posedge clk) pll_locked <= 1'b1;
        idle(8);
        rd("flag_manual", OFS_PLL_CONTROL, 8'h2E);
        rd("lock_manual", OFS_BW_CONTROL, 8'h00);
        @(posedge clk) pll_locked <= 1'b0;
        wr(OFS_BW_CONTROL, 8'h20);
        rd("phase_manual", OFS_BW_CONTROL, 8'h20);
        wr(OFS_BW_CONTROL, 8'hA0);
        idle(8);
        rd("bw_auto", OFS_BW_CONTROL, 8'h80);
        chk("phase_kept", 12'h001, {11'h000, pll_cfg.manual_phase});
        chk("auto_cfg", 12'h001, {11'h000, pll_cfg.auto_bandwidth});
        wr(OFS_PLL_CONTROL, 8'hAE);
        rd("ie_auto", OFS_PLL_CONTROL, 8'hAE);
        @(posedge clk) begin
            pll_locked   <= 1'b1;
            pll_tracking <= 1'b1;
        end
        idle(8);
        chk("irq_set", 12'h001, {11'h000, lock_irq});
        rd("bw_locked", OFS_BW_CONTROL, 8'hE0);
        rd("flag_set", OFS_PLL_CONTROL, 8'hEE);
        idle(3);
        chk("irq_clear", 12'h000, {11'h000, lock_irq});
        rd("flag_clear", OFS_PLL_CONTROL, 8'hAE);
        wr(OFS_PLL_CONTROL, 8'hEE);
        rd("flag_ro", OFS_PLL_CONTROL, 8'hAE);
        @(posedge clk) pll_locked <= 1'b0;
        idle(8);
        rd("flag_fall", OFS_PLL_CONTROL, 8'hEE);
        wr(OFS_BW_CONTROL, 8'h00);
        rd("phase_back", OFS_BW_CONTROL, 8'h20);
        rd("ie_hidden", OFS_PLL_CONTROL, 8'h2E);
    endtask : t_lock
    task automatic report_and_stop;
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        bus_req           = '0;
        srst              = 1'b1;
        pll_locked        = 1'b0;
        pll_tracking      = 1'b0;
        bad_count         = 0;
        comparisons       = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_protect;
        t_clock;
        t_lock;
        report_and_stop;
    end
    // the whole sequence needs about 1000 cycles; twenty times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
endmodule : tb
